// >>> core/dps_sequencer.sv
// Drive power-on clear and start-up sequencer with an APB register port.
// Assumes all pins are synchronous to CORE_CLK, the 50 Hz mains clock is a
// level input, and RST is active while the power supply is not yet up.
//
// Overview of operation
// - Hold power-on clear beyond 60 ms.
// - Power-on clear resets unsafe, pack motor, start.
// - Power-on clear sets exchange preparation.
// - Master clear active until start is set.
// - Master clear resets direction, cartridge, normal seek.
// - Master clear sets slow motion, edge select; clears count.
// - Slow motion resets end-of-position, drives slow seek.
// - Slow motion selects the upper head.
// - Ready only with seat and both clamps closed.
// - Button press with ready sets start.
// - Started: 50 Hz starts pack motor, frees counter.
// - Timing counter steps once per 50 Hz pulse.
// - Stage ten starts the brush motor.
// - Late stage decode ends exchange preparation.
// - Preparation done and brushes retracted stop brushes.
// - Preparation end enables first seek forward.
// - On-cylinder delay done: flags, counter clear, no slow.
//
// The register offsets and the APB register port were left to the implementer.
`timescale 1ns/1ps
module dps_sequencer #(
  parameter logic [23:0] POC_CYCLES = dps_pkg::POC_CYCLES
) (
  // Clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  // Panel and mechanics
  input  wire logic        MAINS_50HZ,
  input  wire logic        SEAT_CLOSED,
  input  wire logic        CLAMP_A_CLOSED,
  input  wire logic        CLAMP_B_CLOSED,
  input  wire logic        START_BUTTON_PRESSED,
  input  wire logic        BRUSHES_RETRACTED,
  input  wire logic        UNSAFE_DETECT,
  // Positioner status
  input  wire logic        SEEK_START,
  input  wire logic        SEEK_DONE,
  input  wire logic        ODD_TRACK,
  input  wire logic        NORMAL_SEEK_COND,
  input  wire logic        ON_CYL_DELAY_DONE,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic      [31:0] PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Sequencer outputs
  output logic             POWER_ON_CLEAR,
  output logic             MASTER_CLEAR,
  output logic             READY_TO_OPERATE,
  output logic             UNSAFE_REPORT,
  output logic             PACK_MOTOR_ON,
  output logic             BRUSH_MOTOR_ON,
  output logic             FIRST_SEEK_FORWARD,
  output logic             POSITIONER_RETRACT,
  output logic             FORWARD_DIRECTION,
  output logic             SLOW_SEEK,
  output logic             POSITIVE_EDGE_SELECT,
  output logic             CONVERTER_MAX_FORCE,
  output logic             COUNT_ENABLE,
  output logic             NORMAL_SEEK,
  output logic      [1:0]  HEAD_SELECT,
  output logic             ON_CYLINDER,
  output logic             ATTENTION,
  output logic             IRQ
);

  // Whole module state
  typedef struct packed {
    logic        power_on_clear;        // Power-on clear
    logic [23:0] poc_cnt;    // Cycles of power-on clear so far
    logic        tick_prev;  // Mains level last cycle
    logic [4:0]  samp;       // Last 50 Hz sample of panel inputs
    logic [4:0]  deb;        // Debounced panel inputs
    logic        btn_prev;   // Debounced button last cycle
    logic        ready_to_operate;        // Ready to operate
    logic        start;      // Start flip-flop
    logic        unsafe;     // Unsafe report
    logic        pack_motor_energise_ff;        // Pack motor energise
    logic        pack_motor_deenergise_ff;        // Pack motor de-energise
    logic        cartridge_exchange_prep_ff;       // Cartridge exchange preparation
    logic        mc;         // Master clear
    logic        dff;        // Forward direction
    logic        cartridge_present_ff;        // Cartridge present
    logic        ns;         // Normal seek
    logic        sm;         // Slow motion
    logic        positive_edge_select;        // Positive edge select
    logic        ec;         // Count enable
    logic        converter_max_force;        // Converter max force
    logic        ep;         // End of positioning
    logic        slow;       // Slow seek
    logic [1:0]  head;       // Head select
    logic        tcz;        // Timing counter clear
    logic [3:0]  tc;         // Timing counter
    logic        brush_motor_enable_ff;        // Brush motor enable
    logic        brush_out;  // Brushes have left the retracted spot
    logic        first_seek_enable_ff;        // First seek enable
    logic        positioner_retract; // Low once the first seek is enabled
    logic        on_cyl;     // On cylinder
    logic        attn;       // Attention
    logic [1:0]  ctrl_head;  // Software head choice
    logic [4:0]  irq_stat;   // Sticky events
    logic [4:0]  irq_mask;   // Event enables
    logic        irq;        // Interrupt output
    logic        pready;     // APB ready
    logic        pslverr;    // APB error
    logic [31:0] prdata;     // APB read data
  } dps_state_t;

  dps_state_t s_reg;  // Registered state
  dps_state_t s_next; // Next state

  logic tick;     // Rising edge of the mains clock
  logic btn_rise; // Debounced button press
  logic wr_en;    // APB write taking effect

  // Known register offset
  function automatic logic dps_addr_ok(input logic [7:0] a);
    dps_addr_ok = (a == dps_pkg::OFS_CTRL) || (a == dps_pkg::OFS_STATE) ||
                  (a == dps_pkg::OFS_IRQ_STAT) ||
                  (a == dps_pkg::OFS_IRQ_MASK);
  endfunction : dps_addr_ok

  // Read mux for one offset
  function automatic logic [31:0] dps_read(input logic [7:0] a,
                                           input dps_state_t st);
    dps_read = dps_pkg::RD_ZERO;
    unique case (a)
      dps_pkg::OFS_CTRL:     dps_read[3:2] = st.ctrl_head;
      dps_pkg::OFS_STATE:    dps_read = {10'h000, st.head, st.tc, 2'h0,
                               st.tcz, st.attn, st.on_cyl, st.sm, st.dff,
                               st.first_seek_enable_ff, st.cartridge_exchange_prep_ff, st.brush_motor_enable_ff, st.pack_motor_energise_ff, st.ready_to_operate,
                               st.unsafe, st.start, st.mc, st.power_on_clear};
      dps_pkg::OFS_IRQ_STAT: dps_read[4:0] = st.irq_stat;
      dps_pkg::OFS_IRQ_MASK: dps_read[4:0] = st.irq_mask;
      default:               dps_read = dps_pkg::RD_ZERO;
    endcase
  endfunction : dps_read

  // Next-state logic
  always_comb begin
    logic [4:0] raw;
    logic [4:0] ev;
    raw = '0;
    ev  = '0;
    s_next = s_reg;
    tick     = MAINS_50HZ & ~s_reg.tick_prev;
    btn_rise = s_reg.deb[dps_pkg::IN_BUTTON] & ~s_reg.btn_prev;
    wr_en    = PSEL & PENABLE & s_reg.pready & PWRITE &
               dps_addr_ok(PADDR);
    s_next.tick_prev = MAINS_50HZ;
    s_next.btn_prev  = s_reg.deb[dps_pkg::IN_BUTTON];

    // Power-on clear held for a fixed count after supply is up
    if (s_reg.power_on_clear) begin
      s_next.poc_cnt = s_reg.poc_cnt + 24'h000001;
      if (s_reg.poc_cnt >= POC_CYCLES - 24'h000001) begin
        s_next.power_on_clear = 1'b0;
      end
    end

    // Panel inputs move only on a 50 Hz edge, after two equal samples
    raw = {BRUSHES_RETRACTED, START_BUTTON_PRESSED, CLAMP_B_CLOSED,
           CLAMP_A_CLOSED, SEAT_CLOSED};
    if (tick) begin
      s_next.samp = raw;
      for (int i = 0; i < 5; i++) begin
        if (raw[i] == s_reg.samp[i]) begin
          s_next.deb[i] = raw[i];
        end
      end
    end
    s_next.ready_to_operate = s_next.deb[dps_pkg::IN_SEAT] &
                 s_next.deb[dps_pkg::IN_CLAMP_A] &
                 s_next.deb[dps_pkg::IN_CLAMP_B];

    // Start and unsafe flip-flops; both blocked without ready
    if (s_reg.power_on_clear) begin
      s_next.start  = 1'b0;
      s_next.unsafe = 1'b0;
      s_next.pack_motor_energise_ff    = 1'b0;
      s_next.cartridge_exchange_prep_ff   = 1'b1;
    end else begin
      if (btn_rise && s_reg.ready_to_operate && !s_reg.start) begin
        s_next.start = 1'b1;
        ev[dps_pkg::EV_START] = 1'b1;
      end else if (btn_rise && s_reg.start) begin
        // Second press stops the drive and raises master clear again
        s_next.start = 1'b0;
      end
      if (UNSAFE_DETECT && s_reg.ready_to_operate && !s_reg.unsafe) begin
        s_next.unsafe = 1'b1;
        ev[dps_pkg::EV_UNSAFE] = 1'b1;
      end
    end

    // Master clear while not started
    s_next.mc = s_next.power_on_clear | ~s_next.start;

    // Pack motor runs from the first 50 Hz pulse after start
    if (s_reg.mc) begin
      s_next.pack_motor_deenergise_ff = 1'b1;
      s_next.pack_motor_energise_ff = 1'b0;
    end else if (tick && s_reg.start) begin
      s_next.pack_motor_deenergise_ff = 1'b0;
      s_next.pack_motor_energise_ff = 1'b1;
    end

    // Timing counter clear
    if (s_reg.mc || ON_CYL_DELAY_DONE) begin
      s_next.tcz = 1'b1;
    end else if (tick && s_reg.start && !s_reg.on_cyl) begin
      s_next.tcz = 1'b0;
    end

    // Timing counter uses the clear as it stood before this edge
    if (s_reg.tcz) begin
      s_next.tc = 4'h0;
    end else if (tick && s_reg.tc != dps_pkg::TC_LAST) begin
      s_next.tc = s_reg.tc + 4'h1;
    end // Held at the last stage otherwise

    // Brush cleaning; the clear waits until the brushes have gone in
    if (s_reg.brush_motor_enable_ff && !s_reg.deb[dps_pkg::IN_BRUSH_RET]) begin
      s_next.brush_out = 1'b1;
    end
    if (s_reg.mc) begin
      s_next.brush_motor_enable_ff       = 1'b0;
      s_next.brush_out = 1'b0;
    end else if (s_reg.brush_motor_enable_ff && !s_reg.cartridge_exchange_prep_ff && s_reg.brush_out &&
                 s_reg.deb[dps_pkg::IN_BRUSH_RET]) begin
      s_next.brush_motor_enable_ff       = 1'b0;
      s_next.brush_out = 1'b0;
    end else if (s_reg.tc == dps_pkg::TC_BRUSH && !s_reg.brush_motor_enable_ff &&
                 !s_reg.brush_out) begin
      s_next.brush_motor_enable_ff = 1'b1;
      ev[dps_pkg::EV_BRUSH] = 1'b1;
    end
    if (!s_reg.power_on_clear && (s_reg.tc == dps_pkg::TC_BRUSH ||
                       s_reg.tc == dps_pkg::TC_LAST)) begin
      s_next.cartridge_exchange_prep_ff = 1'b0;
    end

    // First seek forward on the end of exchange preparation
    if (s_reg.mc) begin
      s_next.first_seek_enable_ff = 1'b0;
      s_next.dff = 1'b0;
    end else if (s_reg.cartridge_exchange_prep_ff && !s_next.cartridge_exchange_prep_ff) begin
      s_next.first_seek_enable_ff = 1'b1;
      s_next.dff = 1'b1;
      ev[dps_pkg::EV_FIRST_SEEK] = 1'b1;
    end
    // Registered so the retract pin comes straight from a flip-flop
    s_next.positioner_retract = ~s_next.first_seek_enable_ff;

    // Cartridge present and normal seek
    if (s_reg.mc) begin
      s_next.cartridge_present_ff = 1'b0;
    end else if (s_reg.ready_to_operate) begin
      s_next.cartridge_present_ff = 1'b1;
    end
    if (!s_reg.cartridge_present_ff) begin
      s_next.ns = 1'b0;
    end else if (NORMAL_SEEK_COND) begin
      s_next.ns = 1'b1;
    end

    // Slow motion, edge select and count enable
    if (s_reg.mc) begin
      s_next.sm  = 1'b1;
      s_next.positive_edge_select = 1'b1;
      s_next.ec  = 1'b0;
    end else begin
      s_next.positive_edge_select = ~ODD_TRACK;
      if (SEEK_START) begin
        s_next.ec = 1'b1;
      end else if (SEEK_DONE) begin
        s_next.ec = 1'b0;
      end
      if (ON_CYL_DELAY_DONE) begin
        s_next.sm = 1'b0;
      end
    end
    s_next.converter_max_force = s_reg.mc ? 1'b0 : (s_reg.ec & ~s_reg.slow);

    // End of positioning, slow seek and head select
    if (s_reg.sm) begin
      s_next.ep   = 1'b0;
      s_next.head = 2'h0;
    end else begin
      s_next.head = s_reg.ctrl_head;
      if (SEEK_START) begin
        s_next.ep = 1'b0;
      end else if (SEEK_DONE) begin
        s_next.ep = 1'b1;
      end
    end
    s_next.slow = s_reg.sm;

    // On cylinder and attention
    if (s_reg.mc || SEEK_START) begin
      s_next.on_cyl = 1'b0;
    end else if (ON_CYL_DELAY_DONE) begin
      s_next.on_cyl = 1'b1;
      ev[dps_pkg::EV_ON_CYL] = 1'b1;
    end
    if (!s_reg.mc && ON_CYL_DELAY_DONE) begin
      s_next.attn = 1'b1;
    end else if (s_reg.mc || (wr_en && PADDR == dps_pkg::OFS_CTRL &&
                              PWDATA[dps_pkg::CTRL_ATTN_ACK])) begin
      s_next.attn = 1'b0;
    end

    // Register writes; a new event wins over its own clear
    if (wr_en) begin
      unique case (PADDR)
        dps_pkg::OFS_CTRL:
          s_next.ctrl_head = PWDATA[dps_pkg::CTRL_HEAD_LO +: 2];
        dps_pkg::OFS_IRQ_STAT:
          s_next.irq_stat = s_reg.irq_stat & ~PWDATA[4:0];
        dps_pkg::OFS_IRQ_MASK: s_next.irq_mask = PWDATA[4:0];
        default: s_next.irq_mask = s_reg.irq_mask;
      endcase
    end
    s_next.irq_stat = s_next.irq_stat | ev;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);

    // APB: data prepared in setup, ready in the first access cycle
    s_next.pready  = PSEL & ~PENABLE;
    s_next.pslverr = PSEL & ~PENABLE & ~dps_addr_ok(PADDR);
    s_next.prdata  = (PSEL && !PENABLE && !PWRITE) ?
                     dps_read(PADDR, s_reg) : dps_pkg::RD_ZERO;
  end

  // State register with synchronous reset
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      s_reg      <= '0;
      s_reg.power_on_clear  <= 1'b1;
      s_reg.mc   <= 1'b1;
      s_reg.cartridge_exchange_prep_ff <= 1'b1;
      s_reg.pack_motor_deenergise_ff  <= 1'b1;
      s_reg.sm   <= 1'b1;
      s_reg.positive_edge_select  <= 1'b1;
      s_reg.slow <= 1'b1;
      s_reg.tcz  <= 1'b1;
      s_reg.positioner_retract <= 1'b1;
      s_reg.deb  <= dps_pkg::DEB_RST;
      s_reg.samp <= dps_pkg::DEB_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign PRDATA               = s_reg.prdata;
  assign PREADY               = s_reg.pready;
  assign PSLVERR              = s_reg.pslverr;
  assign POWER_ON_CLEAR       = s_reg.power_on_clear;
  assign MASTER_CLEAR         = s_reg.mc;
  assign READY_TO_OPERATE     = s_reg.ready_to_operate;
  assign UNSAFE_REPORT        = s_reg.unsafe;
  assign PACK_MOTOR_ON        = s_reg.pack_motor_energise_ff;
  assign BRUSH_MOTOR_ON       = s_reg.brush_motor_enable_ff;
  assign FIRST_SEEK_FORWARD   = s_reg.first_seek_enable_ff;
  assign POSITIONER_RETRACT   = s_reg.positioner_retract;
  assign FORWARD_DIRECTION    = s_reg.dff;
  assign SLOW_SEEK            = s_reg.slow;
  assign POSITIVE_EDGE_SELECT = s_reg.positive_edge_select;
  assign CONVERTER_MAX_FORCE  = s_reg.converter_max_force;
  assign COUNT_ENABLE         = s_reg.ec;
  assign NORMAL_SEEK          = s_reg.ns;
  assign HEAD_SELECT          = s_reg.head;
  assign ON_CYLINDER          = s_reg.on_cyl;
  assign ATTENTION            = s_reg.attn;
  assign IRQ                  = s_reg.irq;

  // Checks on the sequence
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  property p_poc_hold;
    $fell(s_reg.power_on_clear) |-> $past(s_reg.poc_cnt) >= POC_CYCLES - 24'h000001;
  endproperty
  a_poc_hold: assert property (p_poc_hold)
    else $error("Power-on clear released too early");

  property p_poc_resets;
    s_reg.power_on_clear |=> !s_reg.start && !s_reg.unsafe && !s_reg.pack_motor_energise_ff;
  endproperty
  a_poc_resets: assert property (p_poc_resets)
    else $error("Power-on clear left a flip-flop set");

  property p_poc_cartridge_exchange_prep_ff;
    s_reg.power_on_clear |=> s_reg.cartridge_exchange_prep_ff;
  endproperty
  a_poc_cartridge_exchange_prep_ff: assert property (p_poc_cartridge_exchange_prep_ff)
    else $error("Exchange preparation not set by power-on clear");

  property p_mc;
    MASTER_CLEAR == (s_reg.power_on_clear || !s_reg.start);
  endproperty
  a_mc: assert property (p_mc)
    else $error("Master clear does not follow start");

  property p_mc_dir;
    MASTER_CLEAR |=> !FORWARD_DIRECTION && !s_reg.cartridge_present_ff ##1 !NORMAL_SEEK;
  endproperty
  a_mc_dir: assert property (p_mc_dir)
    else $error("Master clear left direction or seek set");

  property p_mc_slow;
    MASTER_CLEAR |=> s_reg.sm && POSITIVE_EDGE_SELECT && !COUNT_ENABLE &&
                     !CONVERTER_MAX_FORCE;
  endproperty
  a_mc_slow: assert property (p_mc_slow)
    else $error("Master clear effects missing");

  property p_sm;
    s_reg.sm |=> !s_reg.ep && SLOW_SEEK && HEAD_SELECT == 2'h0;
  endproperty
  a_sm: assert property (p_sm)
    else $error("Slow motion effects missing");

  property p_head;
    s_reg.sm [*2] |-> HEAD_SELECT == 2'h0;
  endproperty
  a_head: assert property (p_head)
    else $error("Head select not upper under slow motion");

  property p_rto;
    $rose(s_reg.start) |-> $past(READY_TO_OPERATE);
  endproperty
  a_rto: assert property (p_rto)
    else $error("Start set without ready to operate");

  property p_start;
    btn_rise && READY_TO_OPERATE && !s_reg.start && !s_reg.power_on_clear
      |=> s_reg.start && !MASTER_CLEAR;
  endproperty
  a_start: assert property (p_start)
    else $error("Button press did not start the drive");

  property p_pack;
    tick && s_reg.start && !MASTER_CLEAR |=> PACK_MOTOR_ON && !s_reg.pack_motor_deenergise_ff;
  endproperty
  a_pack: assert property (p_pack)
    else $error("Pack motor not started");

  property p_step;
    !s_reg.tcz && tick && s_reg.tc != dps_pkg::TC_LAST
      |=> s_reg.tc == $past(s_reg.tc) + 4'h1;
  endproperty
  a_step: assert property (p_step)
    else $error("Timing counter did not step");

  property p_brush;
    $rose(s_reg.tc == dps_pkg::TC_BRUSH) ##0 !MASTER_CLEAR
      |=> BRUSH_MOTOR_ON;
  endproperty
  a_brush: assert property (p_brush)
    else $error("Brush motor not started at stage ten");

  property p_cartridge_exchange_prep_ff;
    s_reg.tc >= dps_pkg::TC_BRUSH |=> !s_reg.cartridge_exchange_prep_ff;
  endproperty
  a_cartridge_exchange_prep_ff: assert property (p_cartridge_exchange_prep_ff)
    else $error("Exchange preparation not cleared");

  property p_brush_stop;
    BRUSH_MOTOR_ON && !s_reg.cartridge_exchange_prep_ff && s_reg.brush_out &&
      s_reg.deb[dps_pkg::IN_BRUSH_RET] |=> !BRUSH_MOTOR_ON;
  endproperty
  a_brush_stop: assert property (p_brush_stop)
    else $error("Brush motor not stopped");

  property p_first;
    $fell(s_reg.cartridge_exchange_prep_ff) && !MASTER_CLEAR |-> FIRST_SEEK_FORWARD &&
      FORWARD_DIRECTION && !POSITIONER_RETRACT;
  endproperty
  a_first: assert property (p_first)
    else $error("First seek not enabled");

  property p_oncyl;
    ON_CYL_DELAY_DONE && !MASTER_CLEAR |=> ON_CYLINDER && ATTENTION &&
      s_reg.tcz && !s_reg.sm ##1 s_reg.tc == 4'h0;
  endproperty
  a_oncyl: assert property (p_oncyl)
    else $error("On-cylinder effects missing");

  property p_deb;
    !tick |=> $stable(s_reg.deb);
  endproperty
  a_deb: assert property (p_deb)
    else $error("Debounced input moved off a 50 Hz edge");

  property p_hold;
    s_reg.tc == dps_pkg::TC_LAST && !s_reg.tcz
      |=> s_reg.tc == dps_pkg::TC_LAST;
  endproperty
  a_hold: assert property (p_hold)
    else $error("Timing counter left its final stage");

  c_start: cover property ($rose(s_reg.start));
  c_brush: cover property ($rose(BRUSH_MOTOR_ON) ##[1:1000] !BRUSH_MOTOR_ON);
  c_first: cover property ($rose(FIRST_SEEK_FORWARD));
  c_oncyl: cover property ($rose(ON_CYLINDER));

endmodule : dps_sequencer

// >>> core/dps_pkg.sv
// Package for the drive power and start sequencer.
// Assumes a 100 MHz core clock and a 32-bit APB register port.
package dps_pkg;
  // Core clock rate and power-on clear time
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned POC_MIN_MS    = 60;
  // One cycle beyond the minimum, since the hold must exceed it
  localparam logic [23:0] POC_CYCLES    =
    24'(POC_MIN_MS * (CLK_HZ / 1000) + 1);
  // Timing counter stages
  localparam logic [3:0]  TC_BRUSH      = 4'hA;  // Brush motor start
  localparam logic [3:0]  TC_LAST       = 4'hB;  // Final, held stage
  // Register byte offsets
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATE     = 8'h04;
  localparam logic [7:0]  OFS_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  OFS_IRQ_MASK  = 8'h0C;
  // Control register fields
  localparam int          CTRL_ATTN_ACK = 0;     // Write one: drop attention
  localparam int          CTRL_HEAD_LO  = 2;     // Head select, two bits
  // Debounced input vector positions
  localparam int          IN_SEAT       = 0;
  localparam int          IN_CLAMP_A    = 1;
  localparam int          IN_CLAMP_B    = 2;
  localparam int          IN_BUTTON     = 3;
  localparam int          IN_BRUSH_RET  = 4;
  // Interrupt status bits
  localparam int          EV_START      = 0;
  localparam int          EV_BRUSH      = 1;
  localparam int          EV_FIRST_SEEK = 2;
  localparam int          EV_ON_CYL     = 3;
  localparam int          EV_UNSAFE     = 4;
  localparam int          EV_W          = 5;
  // Reset values
  localparam logic [4:0]  DEB_RST       = 5'h10; // Brushes start retracted
  localparam logic [31:0] RD_ZERO       = 32'h0000_0000;
endpackage : dps_pkg

// >>> test/dps_far_side.sv
// Far-side model: mains ticks and the cleaning brush arm.
// Assumes the bench core clock; mains is sped up for simulation.
`timescale 1ns/1ps
module dps_far_side (
  // Clock and motor drive
  input  wire logic clk,
  input  wire logic brush_on,
  // Mechanics back to the block
  output logic      mains,
  output logic      brush_home
);
  logic [2:0] tick_reg = 3'h0; // Mains phase divider
  logic [6:0] arm_reg  = 7'h00; // Cycles the brush motor has run
  // Arm runs only while the motor is powered, then rests at home
  always_ff @(posedge clk) begin
    tick_reg <= tick_reg + 3'h1;
    if (brush_on && arm_reg != 7'h40) begin
      arm_reg <= arm_reg + 7'h01;
    end
  end
  // Eight-cycle mains period keeps the start-up run short
  assign mains = tick_reg[2];
  // Brushes leave home while cleaning, then come back
  assign brush_home = (arm_reg < 7'h10) || (arm_reg == 7'h40);
endmodule : dps_far_side

// >>> test/dps_sequencer_bench.sv
// Self-checking bench for the drive power and start sequencer.
// Assumes a 10 ns core clock and the far-side model for mains and brushes.
`timescale 1ns/1ps
module dps_sequencer_bench;
  localparam logic [23:0] CLR_LEN = 24'h000014; // Short power-on clear
  logic clk = 1'h0, rst = 1'h1, seat = 1'h0, cla = 1'h0, clb = 1'h0;
  logic btn = 1'h0, uns_in = 1'h0, ocd = 1'h0; // Panel and positioner
  logic sks = 1'h0, odd = 1'h0, nsc = 1'h0; // Seek stimulus
  logic psel = 1'h0, pen = 1'h0, pwr = 1'h0; // APB request
  logic [7:0] padr = 8'h00;
  logic [31:0] pwd = 32'h0, prd, q;
  logic rdy, err, e, mains, home, pcl, mcl, ready_to_operate, unsafe_report_ff, pack, brush, first_seek_forward;
  logic ret, fwd, slow, positive_edge_select, maxf, cen, nsk, ocyl, attn, irq;
  logic [1:0] head;
  int n_errors = 0, checks = 0, cyc = 0;
  always #5 clk = ~clk;
  dps_sequencer #(.POC_CYCLES(CLR_LEN)) dps_sequencer_i (
    .CORE_CLK(clk), .RST(rst), .MAINS_50HZ(mains), .SEAT_CLOSED(seat),
    .CLAMP_A_CLOSED(cla), .CLAMP_B_CLOSED(clb), .START_BUTTON_PRESSED(btn),
    .BRUSHES_RETRACTED(home), .UNSAFE_DETECT(uns_in), .SEEK_START(sks),
    .SEEK_DONE(1'h0), .ODD_TRACK(odd), .NORMAL_SEEK_COND(nsc),
    .ON_CYL_DELAY_DONE(ocd), .PSEL(psel), .PENABLE(pen), .PWRITE(pwr),
    .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(rdy), .PSLVERR(err),
    .POWER_ON_CLEAR(pcl), .MASTER_CLEAR(mcl), .READY_TO_OPERATE(ready_to_operate),
    .UNSAFE_REPORT(unsafe_report_ff), .PACK_MOTOR_ON(pack), .BRUSH_MOTOR_ON(brush),
    .FIRST_SEEK_FORWARD(first_seek_forward), .POSITIONER_RETRACT(ret),
    .FORWARD_DIRECTION(fwd), .SLOW_SEEK(slow), .POSITIVE_EDGE_SELECT(positive_edge_select),
    .CONVERTER_MAX_FORCE(maxf), .COUNT_ENABLE(cen), .NORMAL_SEEK(nsk),
    .HEAD_SELECT(head), .ON_CYLINDER(ocyl), .ATTENTION(attn), .IRQ(irq));
  dps_far_side dps_far_side_i (.clk(clk), .brush_on(brush), .mains(mains),
    .brush_home(home));
  // Word compare; case inequality so unknowns never match
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Wait a bounded time for a level, then compare it
  task automatic wt(ref logic s, input logic v);
    int n;
    n = 0;
    while (s !== v && n < 400) begin
      @(posedge clk);
      n++;
    end
    cmp(s, v);
  endtask : wt
  // One APB transfer; request held until PREADY is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'h1;
    pwr <= w;
    padr <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'h1;
    do begin
      @(posedge clk);
    end while (rdy !== 1'h1);
    q = prd;
    e = err;
    psel <= 1'h0;
    pen <= 1'h0;
    @(posedge clk);
  endtask : apb
  // Reset, clear values and power-on clear length
  task automatic t_reset;
    int n;
    n = 0;
    rst <= 1'h1;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    cmp({mcl, slow, positive_edge_select, ret, fwd, cen, maxf, nsk, head, unsafe_report_ff, pack, brush},
        13'h1E00);
    while (pcl === 1'h1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    cmp(n >= CLR_LEN && n <= CLR_LEN + 3, 1'h1);
    cmp(mcl, 1'h1);
    apb(1'h0, dps_pkg::OFS_STATE, 32'h0);
    cmp(q[7], 1'h1);
    $display("Test reset done");
  endtask : t_reset
  // Button and unsafe are ignored while a clamp is open
  task automatic t_refuse;
    seat <= 1'h1;
    btn <= 1'h1;
    uns_in <= 1'h1;
    repeat (40) @(posedge clk);
    cmp({ready_to_operate, mcl, unsafe_report_ff}, 3'h2);
    btn <= 1'h0;
    uns_in <= 1'h0;
    repeat (40) @(posedge clk);
    $display("Test refuse done");
  endtask : t_refuse
  // Full start-up: pack motor, counter, brushes, first seek
  task automatic t_start;
    cla <= 1'h1;
    clb <= 1'h1;
    wt(ready_to_operate, 1'h1);
    btn <= 1'h1;
    wt(mcl, 1'h0);
    btn <= 1'h0;
    wt(pack, 1'h1);
    wt(brush, 1'h1);
    cmp({first_seek_forward, ret, fwd}, 3'h5);
    apb(1'h0, dps_pkg::OFS_STATE, 32'h0);
    cmp({q[19:16], q[13], q[7]},
        {dps_pkg::TC_BRUSH, 2'h0});
    wt(brush, 1'h0);
    repeat (40) @(posedge clk);
    apb(1'h0, dps_pkg::OFS_STATE, 32'h0);
    cmp(q[19:16], dps_pkg::TC_LAST);
    $display("Test start done");
  endtask : t_start
  // Interrupt mask, sticky clear and an unmapped address
  task automatic t_irq;
    cmp(irq, 1'h0);
    apb(1'h1, dps_pkg::OFS_IRQ_MASK, 32'h1 << dps_pkg::EV_START);
    wt(irq, 1'h1);
    apb(1'h1, dps_pkg::OFS_IRQ_STAT, 32'h1 << dps_pkg::EV_START);
    wt(irq, 1'h0);
    apb(1'h0, dps_pkg::OFS_IRQ_STAT, 32'h0);
    cmp(q[2:0], 3'h6);
    apb(1'h1, 8'h10, 32'hFFFF_FFFF);
    cmp(e, 1'h1);
    cmp(q, 32'h0);
    $display("Test irq done");
  endtask : t_irq
  // On-cylinder flags, attention drop, then unsafe with ready
  task automatic t_oncyl;
    ocd <= 1'h1;
    @(posedge clk);
    ocd <= 1'h0;
    wt(ocyl, 1'h1);
    cmp(attn, 1'h1);
    wt(slow, 1'h0);
    apb(1'h0, dps_pkg::OFS_STATE, 32'h0);
    cmp(q[13], 1'h1);
    // Drop attention and pick the lower head in one write
    apb(1'h1, dps_pkg::OFS_CTRL, (32'h2 << dps_pkg::CTRL_HEAD_LO) | 32'h1);
    wt(attn, 1'h0);
    @(posedge clk);
    cmp(head, 2'h2);
    uns_in <= 1'h1;
    wt(unsafe_report_ff, 1'h1);
    uns_in <= 1'h0;
    // A seek on an odd track with the normal seek condition present
    odd <= 1'h1;
    nsc <= 1'h1;
    sks <= 1'h1;
    @(posedge clk);
    sks <= 1'h0;
    repeat (2) @(posedge clk);
    cmp({positive_edge_select, cen, maxf, nsk}, 4'h7);
    // Second press stops; master clear must undo the seek state
    btn <= 1'h1;
    wt(mcl, 1'h1);
    btn <= 1'h0;
    repeat (2) @(posedge clk);
    cmp({fwd, nsk, cen, maxf, positive_edge_select, slow, head},
        7'h0C);
    $display("Test on cylinder done");
  endtask : t_oncyl
  // Report the counts and the verdict, then stop
  task automatic conclude;
    $display("Counts: %0d checks, %0d errors", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  // Hang guard, far above the expected few hundred cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      $display("Error at %0t: timeout", $time);
      n_errors++;
      conclude();
    end
  end
  // Second reset must clear unsafe and the pack motor again
  initial begin
    t_reset();
    t_refuse();
    t_start();
    t_irq();
    t_oncyl();
    t_reset();
    conclude();
  end
endmodule : dps_sequencer_bench
